//--- asr_host.sv
// Notes on behaviour
// RQ1: The RAM holds 16384 one-bit words, chosen by the 14 address lines.
// RQ2: Read with select low and write enable high; RAM drives addressed bit.
// RQ3: Read cycle at least 45 ns between address changes; data valid by then.
// RQ4: Data valid 45 ns after select falls with a stable address.
// RQ5: RAM holds old output at least 5 ns after an address change.
// RQ6: RAM output stays floating at least 5 ns after select falls.
// RQ7: RAM output floats within 30 ns after select rises.
// RQ8: RAM turn-off delay is shorter than turn-on, so shared outputs never fight.
// RQ9: RAM powers up on select, drops to standby within 30 ns after deselect.
// RQ10: Address is valid before or together with select falling for a read.
// RQ11: Write with select and write enable low; write cycle at least 45 ns.
// RQ12: Select low 40 ns before end of write; write enable low 25 ns.
// RQ13: Address stable 40 ns before end of write; zero setup and recovery.
// RQ14: Write data valid 25 ns before end of write, held 0 ns after.
// RQ15: RAM output floats within 25 ns of write enable falling.
// RQ16: RAM may drive output again right after a selected write ends.
// RQ17: Select rising with write enable leaves RAM output floating.
// RQ18: Deselect before supply drop; wait a read cycle after supply returns.
// RQ19: RAM stores the data input value present at the end of write.
module asr_host
	import asr_pkg::*;
(
	input  wire logic     clk_i,
	input  wire logic     sys_rst_i,
	input  wire logic     req_valid_i,
	input  asr_req_s      req_i,
	output logic          req_ready_o,
	output asr_rsp_s      rsp_o,
	input  wire logic     retain_req_i,
	output logic          retain_ok_o,
	input  wire logic     ram_dout_i,
	output asr_pins_s     pins_o
);

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_RD      = 3'b001,
		ST_WR_LOW  = 3'b010,
		ST_WR_REC  = 3'b011,
		ST_RETAIN  = 3'b100,
		ST_RECOVER = 3'b101
	} asr_state_e;

	localparam logic [CNT_W-1:0] RD_LAST   = CNT_W'(RD_CYC - 1);
	localparam logic [CNT_W-1:0] WLOW_LAST = CNT_W'(WLOW_CYC - 1);
	localparam logic [CNT_W-1:0] WREC_LAST = CNT_W'(WREC_CYC - 1);
	localparam logic [CNT_W-1:0] CDR_LAST  = CNT_W'(CDR_CYC - 1);
	localparam logic [CNT_W-1:0] RC_LAST   = CNT_W'(RC_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);

	asr_state_e        state;
	asr_state_e        next_state;
	logic [CNT_W-1:0]  cnt;
	logic [CNT_W-1:0]  next_cnt;
	asr_pins_s         next_pins;
	asr_rsp_s          next_rsp;
	logic              next_ready;
	logic              next_retain_ok;
	logic              dout_sync;
	logic              take;

	// The RAM output is asynchronous to clk_i
	asr_sync u_dout_sync (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.async_i   (ram_dout_i),
		.sync_o    (dout_sync)
	);

	assign take = req_valid_i & req_ready_o;

	always_comb
	begin
		next_state     = state;
		next_cnt       = cnt + CNT_ONE;
		next_pins      = pins_o;
		next_ready     = 1'b0;
		unique case (state)
			ST_IDLE:
			begin
				next_cnt   = '0;
				next_ready = ~retain_req_i & ~take;
				if (retain_req_i && !take)
				begin
					// Select already high here, so standby is entered at once
					next_state     = ST_RETAIN; // see RQ18
					next_pins      = PINS_IDLE;
					next_pins.addr = pins_o.addr;
				end
				else if (take && req_i.write)
				begin
					// Address, data, select and write enable all move on one edge
					next_state          = ST_WR_LOW; // see RQ11
					next_pins.addr      = req_i.addr; // see RQ13
					next_pins.data_in   = req_i.data; // see RQ14
					next_pins.select_n  = 1'b0;
					next_pins.write_en_n = 1'b0;
				end
				else if (take)
				begin
					// Address set on the same edge that drops select
					next_state           = ST_RD; // see RQ10
					next_pins.addr       = req_i.addr; // see RQ1
					next_pins.select_n   = 1'b0; // see RQ2
					next_pins.write_en_n = 1'b1;
				end
			end
			ST_RD:
			begin
				// Hold address for the read cycle plus the synchroniser delay
				if (cnt == RD_LAST) // see RQ3
				begin
					next_state         = ST_IDLE;
					next_pins.select_n = 1'b1; // see RQ9
					next_ready         = ~retain_req_i;
				end
			end
			ST_WR_LOW:
			begin
				if (cnt == WLOW_LAST) // see RQ12
				begin
					// Both strobes rise together so the RAM output never turns on
					next_state           = ST_WR_REC;
					next_cnt             = '0;
					next_pins.select_n   = 1'b1; // see RQ17
					next_pins.write_en_n = 1'b1; // see RQ19
				end
			end
			ST_WR_REC:
			begin
				// Address and data held until the full write cycle has elapsed
				if (cnt == WREC_LAST) // see RQ11
				begin
					next_state = ST_IDLE;
					next_ready = ~retain_req_i;
				end
			end
			ST_RETAIN:
			begin
				if (!retain_req_i)
				begin
					next_state = ST_RECOVER;
					next_cnt   = '0;
				end
				else if (cnt >= CDR_LAST)
				begin
					// Count parks here so it cannot wrap while retention lasts
					next_cnt = cnt;
				end
			end
			ST_RECOVER:
			begin
				if (cnt == RC_LAST) // see RQ18
				begin
					next_state = ST_IDLE;
					next_ready = ~retain_req_i;
				end
			end
			default:
			begin
				next_state = ST_IDLE;
				next_cnt   = '0;
				next_pins  = PINS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			state       <= ST_IDLE;
			cnt         <= '0;
			pins_o      <= PINS_IDLE;
			req_ready_o <= 1'b0;
		end
		else
		begin
			state       <= next_state;
			cnt         <= next_cnt;
			pins_o      <= next_pins;
			req_ready_o <= next_ready;
		end
	end

	// Answer group: the bit is taken on the last read count, after the sync has settled
	always_comb
	begin
		next_rsp = '{valid: 1'b0, data: rsp_o.data};
		if (state == ST_RD && cnt == RD_LAST)
		begin
			next_rsp = '{valid: 1'b1, data: dout_sync}; // see RQ4
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			rsp_o <= '{valid: 1'b0, data: 1'b0};
		end
		else
		begin
			rsp_o <= next_rsp;
		end
	end

	// Supply may be lowered only after this flag rises; it drops as soon as the ask ends
	always_comb
	begin
		next_retain_ok = 1'b0;
		if (state == ST_RETAIN && retain_req_i && cnt >= CDR_LAST)
		begin
			next_retain_ok = 1'b1; // see RQ18
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			retain_ok_o <= 1'b0;
		end
		else
		begin
			retain_ok_o <= next_retain_ok;
		end
	end

endmodule : asr_host

//--- asr_host_bench.sv
module asr_host_bench
	import asr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic      clk_i = 1'b0;
	logic      sys_rst_i = 1'b1;
	logic      req_valid_i = 1'b0;
	logic      retain_req_i = 1'b0;
	logic      req_ready_o;
	logic      retain_ok_o;
	logic      ram_dout_i;
	logic      q;
	asr_req_s  req_i = '0;
	asr_rsp_s  rsp_o;
	asr_pins_s pins_o;
	int        bad_count = 0;
	int        cmp_count = 0;
	always #10 clk_i = ~clk_i;
	asr_host asr_host_i (.clk_i, .sys_rst_i, .req_valid_i, .req_i, .req_ready_o, .rsp_o,
		.retain_req_i, .retain_ok_o, .ram_dout_i, .pins_o);
	asr_ram_model asr_ram_model_i (.pins_i(pins_o), .dout_o(ram_dout_i));
	task check(input logic [16:0] seen, input logic [16:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask : check
	task finish_test;
		if (bad_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	task do_req(input logic wr, input logic [ADDR_W-1:0] a, input logic d);
		int n;
		n = 0;
		@(negedge clk_i);
		req_i = '{write: wr, addr: a, data: d};
		req_valid_i = 1'b1;
		while (req_ready_o !== 1'b1 && n < 40)
		begin
			@(negedge clk_i);
			n++;
		end
		check(17'(req_ready_o), 17'h0_0001);
		@(negedge clk_i);
		req_valid_i = 1'b0;
		n = 0;
		while (!wr && rsp_o.valid !== 1'b1 && n < 9)
		begin
			@(negedge clk_i);
			n++;
		end
		if (!wr)
			check(17'(n), 17'(RD_CYC));
		q = rsp_o.data;
	endtask : do_req
	task t_rw;
		logic [ADDR_W-1:0] a[4];
		a = '{14'h0000, 14'h0001, 14'h3fff, 14'h3ffe};
		for (int i = 0; i < 4; i++)
			do_req(1'b1, a[i], !i[0]);
		for (int i = 0; i < 4; i++)
		begin
			do_req(1'b0, a[i], 1'b0);
			check(17'(q), 17'(!i[0]));
		end
	endtask : t_rw
	// Retention entered with no request pending, since a take wins over it
	task t_retain;
		@(negedge clk_i);
		retain_req_i = 1'b1;
		repeat (4) @(negedge clk_i);
		check(17'(retain_ok_o), 17'h0_0001);
		check(17'(pins_o.select_n), 17'h0_0001);
		retain_req_i = 1'b0;
		do_req(1'b0, 14'h3fff, 1'b0);
		check(17'(q), 17'h0_0001);
	endtask : t_retain
	initial
	begin
		repeat (5) @(negedge clk_i);
		check(pins_o, PINS_IDLE);
		sys_rst_i = 1'b0;
		t_rw;
		t_retain;
		finish_test;
	end
	initial
	begin
		#100us;
		bad_count++;
		finish_test;
	end
endmodule : asr_host_bench
bind asr_host asr_host_chk asr_host_chk_i (.clk_i, .sys_rst_i, .req_valid_i, .req_i,
	.req_ready_o, .rsp_o, .retain_req_i, .retain_ok_o, .pins_o);

//--- asr_host_chk.sv
module asr_host_chk
	import asr_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic req_valid_i,
	input asr_req_s  req_i,
	input wire logic req_ready_o,
	input asr_rsp_s  rsp_o,
	input wire logic retain_req_i,
	input wire logic retain_ok_o,
	input asr_pins_s pins_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic take;
	assign take = req_valid_i && req_ready_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// Answer is registered on the fifth edge after the take, so it is sampled on the sixth
	a_read_answer: assert property (take && !req_i.write |-> ##6 rsp_o.valid)
		else $error("read answer late");
	a_write_space: assert property (take && req_i.write
		|=> !req_ready_o[*3] ##1 req_ready_o)
		else $error("write spacing wrong");
	a_read_select: assert property ($fell(pins_o.select_n) && pins_o.write_en_n
		|-> !pins_o.select_n[*5] ##1 pins_o.select_n)
		else $error("read select length wrong");
	a_write_pulse: assert property ($fell(pins_o.write_en_n)
		|-> !pins_o.write_en_n[*2] ##1 pins_o.write_en_n)
		else $error("write pulse length wrong");
	a_end_together: assert property ($rose(pins_o.write_en_n)
		|-> $rose(pins_o.select_n))
		else $error("write end split");
	a_addr_steady: assert property (!pins_o.select_n
		&& !$past(pins_o.select_n) |-> $stable(pins_o.addr))
		else $error("address moved while selected");
	a_data_steady: assert property (!pins_o.write_en_n
		&& !$past(pins_o.write_en_n) |-> $stable(pins_o.data_in))
		else $error("write data moved");
	a_retain_wait: assert property ($rose(retain_ok_o)
		|-> $past(retain_req_i, 3) && pins_o.select_n && $past(pins_o.select_n, 1)
		&& $past(pins_o.select_n, 2) && !req_ready_o)
		else $error("retention early");
endmodule : asr_host_chk

//--- asr_pkg.sv
package asr_pkg;

	localparam int ADDR_W = 14;
	localparam int WORDS  = 16384;

	localparam int CLK_NS = 20;

	// Slower speed grade timing, in ns
	localparam int T_RC_NS  = 45;
	localparam int T_WC_NS  = 45;
	localparam int T_CW_NS  = 40;
	localparam int T_AW_NS  = 40;
	localparam int T_WP_NS  = 25;
	localparam int T_DW_NS  = 25;
	localparam int DESELECT_BEFORE_RETENTION_NS = 30;

	// Least times round up to whole cycles
	localparam int RC_CYC  = (T_RC_NS + CLK_NS - 1) / CLK_NS;
	localparam int WC_CYC  = (T_WC_NS + CLK_NS - 1) / CLK_NS;
	localparam int CW_CYC  = (T_CW_NS + CLK_NS - 1) / CLK_NS;
	localparam int AW_CYC  = (T_AW_NS + CLK_NS - 1) / CLK_NS;
	localparam int WP_CYC  = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int DW_CYC  = (T_DW_NS + CLK_NS - 1) / CLK_NS;
	localparam int CDR_CYC = (DESELECT_BEFORE_RETENTION_NS + CLK_NS - 1) / CLK_NS;

	localparam int WLOW_A   = (CW_CYC > AW_CYC) ? CW_CYC : AW_CYC;
	localparam int WLOW_B   = (WP_CYC > DW_CYC) ? WP_CYC : DW_CYC;
	localparam int WLOW_CYC = (WLOW_A > WLOW_B) ? WLOW_A : WLOW_B;
	localparam int WREC_CYC = (WC_CYC > WLOW_CYC) ? (WC_CYC - WLOW_CYC) : 1;

	// Read data passes a two-flop synchroniser before it is captured
	localparam int SYNC_CYC = 2;
	localparam int RD_CYC   = RC_CYC + SYNC_CYC;

	localparam int CNT_W = 3;

	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic              data;
	} asr_req_s;

	typedef struct packed {
		logic valid;
		logic data;
	} asr_rsp_s;

	typedef struct packed {
		logic              select_n;
		logic              write_en_n;
		logic [ADDR_W-1:0] addr;
		logic              data_in;
	} asr_pins_s;

	localparam asr_pins_s PINS_IDLE = '{select_n: 1'b1, write_en_n: 1'b1,
		addr: 14'h0000, data_in: 1'b0};

endpackage : asr_pkg

//--- asr_ram_model.sv
module asr_ram_model
	import asr_pkg::*;
(
	input  asr_pins_s pins_i,
	output logic      dout_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [WORDS-1:0] mem = '0;
	logic             rd = 1'b0;
	logic             last = 1'b0;
	logic             drv;
	logic             wr;
	assign wr = !pins_i.select_n && !pins_i.write_en_n;
	// Released pin shows the inverse of the last bit read, so a stale bit never passes
	always @(pins_i or mem)
	begin
		drv = !pins_i.select_n && pins_i.write_en_n;
		if (drv)
			last = mem[pins_i.addr];
		rd = drv ? last : !last;
		if (drv)
			dout_o <= #45 rd;
		else
			dout_o <= #25 rd;
	end
	always @(negedge wr)
		mem[pins_i.addr] <= pins_i.data_in;
endmodule : asr_ram_model

//--- asr_sync.sv
module asr_sync
	import asr_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	input  wire logic async_i,
	output logic      sync_o
);

	logic meta;
	logic next_meta;
	logic next_sync;

	always_comb
	begin
		next_meta = async_i;
		next_sync = meta;
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			meta   <= 1'b0;
			sync_o <= 1'b0;
		end
		else
		begin
			meta   <= next_meta;
			sync_o <= next_sync;
		end
	end

endmodule : asr_sync
